// file: logic/itc_pkg.sv
package itc_pkg;

   // Counter widths
   localparam int LEG_W = 8;                // Legacy up-counter width
   localparam int CH_W  = 16;               // Array down-counter width
   localparam int PSC_W = 16;               // Shared prescaler width
   localparam int LSD_W = 9;                // Low-speed clock divider width

   // Array layout defaults
   localparam int UNITS_DEF   = 2;          // Array units
   localparam int CH_PER_UNIT = 8;          // Channels per unit
   localparam int SPECIAL_CH  = 5;          // Channel with extra sources
   localparam int LEGACY_NUM  = 2;          // Legacy timers 0 and 1

   // System clock rate
   localparam int SYS_CLK_HZ = 50_000_000;  // 20 ns period

   // Legacy timer 0 count clock selection
   localparam logic [2:0] L0_SEL_DIV1    = 3'h0;
   localparam logic [2:0] L0_SEL_DIV2    = 3'h1;
   localparam logic [2:0] L0_SEL_DIV4    = 3'h2;
   localparam logic [2:0] L0_SEL_DIV64   = 3'h3;
   localparam logic [2:0] L0_SEL_DIV1024 = 3'h4;
   localparam logic [2:0] L0_SEL_EXT     = 3'h5;

   // Legacy timer 1 count clock selection
   localparam logic [2:0] L1_SEL_DIV1    = 3'h0;
   localparam logic [2:0] L1_SEL_DIV4    = 3'h1;
   localparam logic [2:0] L1_SEL_DIV16   = 3'h2;
   localparam logic [2:0] L1_SEL_DIV64   = 3'h3;
   localparam logic [2:0] L1_SEL_DIV4096 = 3'h4;
   localparam logic [2:0] L1_SEL_LS      = 3'h5;
   localparam logic [2:0] L1_SEL_LS128   = 3'h6;
   localparam logic [2:0] L1_SEL_LS512   = 3'h7;

   // Prescaler and low-speed divider exponents used by the legacy selections
   localparam logic [3:0] EXP_1    = 4'h0;
   localparam logic [3:0] EXP_2    = 4'h1;
   localparam logic [3:0] EXP_4    = 4'h2;
   localparam logic [3:0] EXP_16   = 4'h4;
   localparam logic [3:0] EXP_64   = 4'h6;
   localparam logic [3:0] EXP_1024 = 4'hA;
   localparam logic [3:0] EXP_4096 = 4'hC;
   localparam logic [3:0] EXP_LS128 = 4'h7;
   localparam logic [3:0] EXP_LS512 = 4'h9;

   // Channel 5 count clock source
   typedef enum logic [1:0] {
      itc_src_prescale,
      itc_src_subsystem,
      itc_src_low_speed,
      itc_src_spare
   } itc_src_type;

   // Reset values
   localparam logic [LEG_W-1:0] LEG_CNT_RST = 8'h00;
   localparam logic [CH_W-1:0]  CH_CNT_RST  = 16'h0000;
   localparam logic [PSC_W-1:0] PSC_RST     = 16'h0000;
   localparam logic [LSD_W-1:0] LSD_RST     = 9'h000;

endpackage

// file: logic/itc_timer.sv
`timescale 1ns/100ps

module itc_timer #(
   parameter int NUM_UNITS = itc_pkg::UNITS_DEF
) (
   // Clock and reset
   input  wire logic                                   clock,
   input  wire logic                                   rst_b,
   // Asynchronous clock pins
   input  wire logic                      subsystem_clock,
   input  wire logic                      low_speed_internal_clock,
   input  wire logic                      external_8bit_timer_output,
   // Legacy timer controls
   input  wire logic [1:0]                legacy_run_enable,
   input  wire logic [1:0][2:0]           legacy_clock_select,
   input  wire logic [1:0][itc_pkg::LEG_W-1:0] legacy_compare,
   // Legacy timer outputs
   output logic [1:0]                     legacy_interval_irq,
   // Array unit controls
   input  wire logic [NUM_UNITS-1:0]      array_clock_supply_enable,
   input  wire logic [NUM_UNITS*8-1:0]    channel_start_trigger,
   input  wire logic [NUM_UNITS*8-1:0]    channel_stop_trigger,
   input  wire logic [NUM_UNITS*8-1:0]    start_interrupt_select,
   input  wire logic [NUM_UNITS*8-1:0][3:0] channel_prescale_select,
   input  wire itc_pkg::itc_src_type [NUM_UNITS-1:0] channel5_source_select,
   input  wire logic [NUM_UNITS*8-1:0][itc_pkg::CH_W-1:0]
                                          channel_data_reload,
   // Array unit outputs
   output logic [NUM_UNITS*8-1:0]         channel_irq,
   output logic [NUM_UNITS*8-1:0]         channel_running,
   output logic [NUM_UNITS*8-1:0][itc_pkg::CH_W-1:0] channel_counter
);
   import itc_pkg::*;

   localparam int NCH = NUM_UNITS * CH_PER_UNIT;  // Flat channel count

   // Two units are documented; one is allowed for small builds
   initial begin
      if (NUM_UNITS < 1 || NUM_UNITS > 2) begin
         $error("itc_timer: NUM_UNITS must be 1 or 2");
      end
   end

   // Whole state of the block in one register
   typedef struct packed {
      logic [PSC_W-1:0]             psc;       // Free-running prescaler
      logic [LSD_W-1:0]             lsd;       // Low-speed clock divider
      logic [2:0]                   sub_sync;  // Sync chain plus history
      logic [2:0]                   ls_sync;   // Sync chain plus history
      logic [2:0]                   ext_sync;  // Sync chain plus history
      logic [1:0][LEG_W-1:0]        leg_cnt;   // Legacy up-counters
      logic [1:0]                   leg_irq;   // Legacy interrupt pulses
      logic [NCH-1:0][CH_W-1:0]     ch_cnt;    // Channel down-counters
      logic [NCH-1:0]               ch_run;    // Channel running flags
      logic [NCH-1:0]               ch_irq;    // Channel interrupt pulses
   } itc_state_type;

   itc_state_type st_q;   // Registered state
   itc_state_type st_d;   // Next state

   // Tick for a divide by 2^e taken from the prescaler
   function automatic logic div_tick(input logic [PSC_W-1:0] cnt,
                                     input logic [3:0]       e);
      logic [PSC_W-1:0] mask;
      mask = ~(16'hFFFF << e);
      return (cnt & mask) == mask;
   endfunction

   // Helper signals derived from the current state
   logic sub_rise;        // Subsystem clock rising edge
   logic ls_rise;         // Low-speed clock rising edge
   logic ext_rise;        // External timer output rising edge
   logic [1:0] leg_tick;  // Legacy count enables
   logic [NCH-1:0] ch_tick; // Channel count enables

   // Edges come only from the second and third stages
   always_comb begin
      sub_rise = st_q.sub_sync[1] & ~st_q.sub_sync[2];
      ls_rise  = st_q.ls_sync[1] & ~st_q.ls_sync[2];
      ext_rise = st_q.ext_sync[1] & ~st_q.ext_sync[2];
   end

   // Count clock selection for the legacy timers
   always_comb begin
      leg_tick = 2'b00;
      // Timer 0: prescaler taps or the external timer output
      unique case (legacy_clock_select[0])
         L0_SEL_DIV1:    leg_tick[0] = div_tick(st_q.psc, EXP_1);
         L0_SEL_DIV2:    leg_tick[0] = div_tick(st_q.psc, EXP_2);
         L0_SEL_DIV4:    leg_tick[0] = div_tick(st_q.psc, EXP_4);
         L0_SEL_DIV64:   leg_tick[0] = div_tick(st_q.psc, EXP_64);
         L0_SEL_DIV1024: leg_tick[0] = div_tick(st_q.psc, EXP_1024);
         L0_SEL_EXT:     leg_tick[0] = ext_rise;
         // Unused codes leave the timer without a clock
         default:        leg_tick[0] = 1'b0;
      endcase
      // Timer 1: prescaler taps or the low-speed oscillator
      unique case (legacy_clock_select[1])
         L1_SEL_DIV1:    leg_tick[1] = div_tick(st_q.psc, EXP_1);
         L1_SEL_DIV4:    leg_tick[1] = div_tick(st_q.psc, EXP_4);
         L1_SEL_DIV16:   leg_tick[1] = div_tick(st_q.psc, EXP_16);
         L1_SEL_DIV64:   leg_tick[1] = div_tick(st_q.psc, EXP_64);
         L1_SEL_DIV4096: leg_tick[1] = div_tick(st_q.psc, EXP_4096);
         L1_SEL_LS:      leg_tick[1] = ls_rise;
         L1_SEL_LS128: begin
            leg_tick[1] = ls_rise &
                          (st_q.lsd[EXP_LS128-1:0] == '1);
         end
         L1_SEL_LS512: begin
            leg_tick[1] = ls_rise &
                          (st_q.lsd[EXP_LS512-1:0] == '1);
         end
      endcase
   end

   // Count clock selection for the array channels
   always_comb begin
      ch_tick = '0;
      for (int i = 0; i < NCH; i++) begin
         // Default source is the prescaler tap
         ch_tick[i] = div_tick(st_q.psc,
                               channel_prescale_select[i]);
         // Only the special channel may pick another source
         if (i % CH_PER_UNIT == SPECIAL_CH) begin
            unique case (channel5_source_select[i / CH_PER_UNIT])
               itc_src_prescale: ch_tick[i] = ch_tick[i];
               itc_src_subsystem: ch_tick[i] = sub_rise;
               itc_src_low_speed: ch_tick[i] = ls_rise;
               itc_src_spare:     ch_tick[i] = 1'b0;
            endcase
         end
         // A unit without its clock supply does not count
         if (!array_clock_supply_enable[i / CH_PER_UNIT]) begin
            ch_tick[i] = 1'b0;
         end
      end
   end

   // Next-state logic for the whole block
   always_comb begin
      st_d = st_q;

      // Prescaler runs freely on the system clock
      st_d.psc = st_q.psc + 16'h0001;

      // Divider of the low-speed oscillator edges
      if (ls_rise) begin
         st_d.lsd = st_q.lsd + 9'h001;
      end

      // Two-flop synchronisers, third stage only for edges
      st_d.sub_sync = {st_q.sub_sync[1:0], subsystem_clock};
      st_d.ls_sync  = {st_q.ls_sync[1:0], low_speed_internal_clock};
      st_d.ext_sync = {st_q.ext_sync[1:0], external_8bit_timer_output};

      // Legacy timers: 8-bit up-counters with compare
      for (int n = 0; n < LEGACY_NUM; n++) begin
         st_d.leg_irq[n] = 1'b0;
         if (!legacy_run_enable[n]) begin
            // Stopped timer holds a cleared counter
            st_d.leg_cnt[n] = LEG_CNT_RST;
         end else if (leg_tick[n]) begin
            if (st_q.leg_cnt[n] == legacy_compare[n]) begin
               // Match: raise the request and restart from zero
               st_d.leg_irq[n] = 1'b1;
               st_d.leg_cnt[n] = LEG_CNT_RST;
            end else begin
               st_d.leg_cnt[n] = st_q.leg_cnt[n] + 8'h01;
            end
         end
      end

      // Array channels: 16-bit reload down-counters
      for (int i = 0; i < NCH; i++) begin
         st_d.ch_irq[i] = 1'b0;
         if (!array_clock_supply_enable[i / CH_PER_UNIT]) begin
            // Triggers are ignored while the unit is unclocked
            st_d.ch_run[i] = st_q.ch_run[i];
         end else if (channel_start_trigger[i]) begin
            // Start wins over a stop in the same cycle
            st_d.ch_run[i] = 1'b1;
            st_d.ch_cnt[i] = channel_data_reload[i];
            st_d.ch_irq[i] = start_interrupt_select[i];
         end else if (channel_stop_trigger[i]) begin
            // Counter value is kept for reading after a stop
            st_d.ch_run[i] = 1'b0;
         end else if (st_q.ch_run[i] && ch_tick[i]) begin
            if (st_q.ch_cnt[i] == CH_CNT_RST) begin
               // Tick after zero: request and reload
               st_d.ch_irq[i] = 1'b1;
               st_d.ch_cnt[i] = channel_data_reload[i];
            end else begin
               // Reload plus one ticks per period
               st_d.ch_cnt[i] = st_q.ch_cnt[i] - 16'h0001;
            end
         end
      end
   end

   // Single state register with synchronous reset
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st_q.psc      <= PSC_RST;
         st_q.lsd      <= LSD_RST;
         st_q.sub_sync <= 3'h0;
         st_q.ls_sync  <= 3'h0;
         st_q.ext_sync <= 3'h0;
         st_q.leg_cnt  <= '0;
         st_q.leg_irq  <= '0;
         st_q.ch_cnt   <= '0;
         st_q.ch_run   <= '0;
         st_q.ch_irq   <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs come straight from the state register
   always_comb begin
      legacy_interval_irq = st_q.leg_irq;
      channel_irq         = st_q.ch_irq;
      channel_running     = st_q.ch_run;
      channel_counter     = st_q.ch_cnt;
   end

endmodule

// file: bench/itc_timer_chk.sv
`timescale 1ns/100ps
module itc_timer_chk #(
   parameter int NUM_UNITS = 2
) (
   // Clock and reset
   input wire logic                          clock,
   input wire logic                          rst_b,
   // Legacy timers
   input wire logic [1:0]                    legacy_run_enable,
   input wire logic [1:0][2:0]               legacy_clock_select,
   input wire logic [1:0][7:0]               legacy_compare,
   input wire logic [1:0]                    legacy_interval_irq,
   // Array channels
   input wire logic [NUM_UNITS-1:0]          array_clock_supply_enable,
   input wire logic [NUM_UNITS*8-1:0]        channel_start_trigger,
   input wire logic [NUM_UNITS*8-1:0]        channel_stop_trigger,
   input wire logic [NUM_UNITS*8-1:0]        start_interrupt_select,
   input wire logic [NUM_UNITS*8-1:0][3:0]   channel_prescale_select,
   input wire logic [NUM_UNITS*8-1:0][15:0]  channel_data_reload,
   input wire logic [NUM_UNITS*8-1:0]        channel_irq,
   input wire logic [NUM_UNITS*8-1:0]        channel_running,
   input wire logic [NUM_UNITS*8-1:0][15:0]  channel_counter
);
   import itc_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Four-tick gaps, watched at the undivided clock only
   sequence s_leg_gap;
      (!legacy_interval_irq[0])[*3] ##1 legacy_interval_irq[0];
   endsequence
   sequence s_ch_gap;
      (!channel_irq[0])[*3] ##1 channel_irq[0];
   endsequence
   a_reset_quiet: assert property (disable iff (1'b0)
      !rst_b |=> legacy_interval_irq == '0 && channel_irq == '0
      && channel_running == '0) else $error("Output active after reset");
   a_leg_period: assert property (
      disable iff (!rst_b || !legacy_run_enable[0])
      legacy_interval_irq[0] && legacy_compare[0] == 8'h03
      && legacy_clock_select[0] == L0_SEL_DIV1 |=> s_leg_gap)
      else $error("Legacy period wrong");
   a_leg_idle: assert property (
      !legacy_run_enable[0] |=> !legacy_interval_irq[0])
      else $error("Legacy irq while stopped");
   a_ch_period: assert property (
      disable iff (!rst_b || !channel_running[0])
      channel_irq[0] && channel_data_reload[0] == 16'h0003
      && channel_prescale_select[0] == 4'h0 |=> s_ch_gap)
      else $error("Channel period wrong");
   a_start_load: assert property (
      array_clock_supply_enable[0] && channel_start_trigger[0] |=>
      channel_running[0] && channel_counter[0] == $past(channel_data_reload[0]))
      else $error("Start did not load");
   a_start_irq: assert property (
      array_clock_supply_enable[0] && channel_start_trigger[0]
      && start_interrupt_select[0] |=> channel_irq[0])
      else $error("No irq at start");
   a_stop_halt: assert property (
      array_clock_supply_enable[0] && channel_stop_trigger[0]
      && !channel_start_trigger[0] |=> !channel_running[0])
      else $error("Stop ignored");
   a_irq_reload: assert property (
      channel_irq[0] |-> channel_counter[0] == channel_data_reload[0])
      else $error("Counter not reloaded at irq");
   a_gated_unit: assert property (
      !array_clock_supply_enable[0] && !channel_running[0]
      |=> !channel_running[0]) else $error("Gated unit started");
endmodule
bind itc_timer itc_timer_chk #(.NUM_UNITS(NUM_UNITS)) chk_u (
   .clock(clock), .rst_b(rst_b), .legacy_run_enable(legacy_run_enable),
   .legacy_clock_select(legacy_clock_select),
   .legacy_compare(legacy_compare), .legacy_interval_irq(legacy_interval_irq),
   .array_clock_supply_enable(array_clock_supply_enable),
   .channel_start_trigger(channel_start_trigger),
   .channel_stop_trigger(channel_stop_trigger),
   .start_interrupt_select(start_interrupt_select),
   .channel_prescale_select(channel_prescale_select),
   .channel_data_reload(channel_data_reload), .channel_irq(channel_irq),
   .channel_running(channel_running), .channel_counter(channel_counter));

// file: bench/itc_timer_tb.sv
`timescale 1ns/100ps
module itc_timer_tb;
   import itc_pkg::*;
   // Drives and observations, one unit only
   logic              clock = 1'b0;
   logic              rst_b = 1'b0;
   logic [1:0]        l_run = '0;
   logic [1:0][2:0]   l_sel = '0;
   logic [1:0][7:0]   l_cmp = '0;
   logic [1:0]        l_irq;
   logic [0:0]        u_en = '0;
   logic [7:0]        c_go = '0;
   logic [7:0]        c_halt = '0;
   logic [7:0]        c_sirq = '0;
   logic [7:0][3:0]   c_psc = '0;
   logic [7:0][15:0]  c_rld = '0;
   logic [7:0]        c_irq;
   logic [7:0]        c_run;
   logic [7:0][15:0]  c_cnt;
   int                n_errors = 0;
   int                checks_done = 0;
   int                cycles = 0;
   logic [3:0]        slow_q = '0;   // Slow pin source, edge every 16
   itc_src_type [0:0] c5_src = itc_src_prescale;
   itc_timer #(.NUM_UNITS(1)) dut_u (
      .clock(clock), .rst_b(rst_b), .subsystem_clock(slow_q[3]),
      .low_speed_internal_clock(slow_q[3]),
      .external_8bit_timer_output(slow_q[3]),
      .legacy_run_enable(l_run), .legacy_clock_select(l_sel),
      .legacy_compare(l_cmp), .legacy_interval_irq(l_irq),
      .array_clock_supply_enable(u_en), .channel_start_trigger(c_go),
      .channel_stop_trigger(c_halt), .start_interrupt_select(c_sirq),
      .channel_prescale_select(c_psc),
      .channel5_source_select(c5_src),
      .channel_data_reload(c_rld), .channel_irq(c_irq),
      .channel_running(c_run), .channel_counter(c_cnt));
   // Free clock, 20 ns period
   always #10 clock = ~clock;
   // Slow pins toggle off the system clock, period 16 cycles
   always @(posedge clock) slow_q <= slow_q + 4'h1;
   // Hang guard, well above the longest prescaler walk
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         n_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (n_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Index 0-1 legacy timers, 2 and up array channels
   function automatic logic irq_of(int k);
      return (k < 2) ? l_irq[k] : c_irq[k-2];
   endfunction
   // Cycles to the next irq, then the gap to the one after
   task automatic gap_of(int k, output int first, output int gap);
      first = 0;
      gap = 0;
      while (irq_of(k) !== 1'b1 && first < 9000) begin
         @(posedge clock); #1; first++;
      end
      do begin
         @(posedge clock); #1; gap++;
      end while (irq_of(k) !== 1'b1 && gap < 9000);
   endtask
   task automatic t_legacy(int n, logic [2:0] sel, logic [7:0] cmp, int tk);
      int f;
      int g;
      int hits;
      @(posedge clock);
      l_sel[n] <= sel;
      l_cmp[n] <= cmp;
      l_run[n] <= 1'b1;
      gap_of(n, f, g);
      chk("legacy gap", g, (cmp + 1) * tk);
      @(posedge clock);
      l_run[n] <= 1'b0;
      hits = 0;
      repeat ((cmp + 1) * tk * 2) begin
         @(posedge clock); #1;
         if (irq_of(n) === 1'b1) hits++;
      end
      chk("legacy idle irqs", hits, 0);
      @(posedge clock);
      l_run[n] <= 1'b1;
      gap_of(n, f, g);
      chk("legacy first", f > cmp * tk && f <= (cmp + 1) * tk, 1);
      @(posedge clock);
      l_run[n] <= 1'b0;
   endtask
   task automatic t_chan(int c, logic [3:0] e, logic [15:0] rld, int tk);
      int f;
      int g;
      logic [15:0] held;
      @(posedge clock);
      u_en <= 1'b0;
      c_psc[c] <= e;
      c_rld[c] <= rld;
      c_sirq[c] <= 1'b1;
      c_go[c] <= 1'b1;
      @(posedge clock);
      c_go[c] <= 1'b0;
      #1 chk("gated start", c_run[c], 0);
      @(posedge clock);
      u_en <= 1'b1;
      c_go[c] <= 1'b1;
      @(posedge clock);
      c_go[c] <= 1'b0;
      #1 chk("running", c_run[c], 1);
      chk("start irq", c_irq[c], 1);
      chk("start load", c_cnt[c], rld);
      gap_of(c + 2, f, g);
      gap_of(c + 2, f, g);
      chk("channel gap", g, (rld + 1) * tk);
      chk("irq reload", c_cnt[c], rld);
      @(posedge clock);
      c_halt[c] <= 1'b1;
      @(posedge clock);
      c_halt[c] <= 1'b0;
      #1 chk("stopped", c_run[c], 0);
      held = c_cnt[c];
      repeat (8) @(posedge clock);
      #1 chk("held count", c_cnt[c], held);
      @(posedge clock);
      c_sirq[c] <= 1'b0;
      c_go[c] <= 1'b1;
      @(posedge clock);
      c_go[c] <= 1'b0;
      c_halt[c] <= 1'b1;
      #1 chk("quiet start", c_irq[c], 0);
      chk("restart load", c_cnt[c], rld);
      @(posedge clock);
      c_halt[c] <= 1'b0;
   endtask
   initial begin
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      #1 chk("reset quiet", {l_irq, c_irq, c_run, c_cnt[0]} != 0, 0);
      t_legacy(0, L0_SEL_DIV1, 8'h03, 1);
      t_legacy(0, L0_SEL_DIV2, 8'h02, 2);
      t_legacy(0, L0_SEL_DIV4, 8'h01, 4);
      t_legacy(0, L0_SEL_DIV1024, 8'h00, 1024);
      t_legacy(1, L1_SEL_DIV1, 8'hFF, 1);
      t_legacy(1, L1_SEL_DIV16, 8'h01, 16);
      t_legacy(1, L1_SEL_DIV4096, 8'h00, 4096);
      t_legacy(0, L0_SEL_EXT, 8'h01, 16);
      t_legacy(1, L1_SEL_LS, 8'h01, 16);
      t_chan(0, 4'h0, 16'h0003, 1);
      t_chan(5, 4'h3, 16'h0002, 8);
      t_chan(7, 4'h4, 16'h0000, 16);
      @(posedge clock);
      c5_src[0] <= itc_src_subsystem;
      t_chan(5, 4'h0, 16'h0002, 16);
      wrap_up();
   end
endmodule
